// [hw/timing_pkg.sv]
package timing_pkg;
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned RATE_MAX_HZ = 10_000_000;
  localparam int unsigned RATE_MIN_QHZ = 1;       // quarter hertz units
  localparam int unsigned SLOW_RATE_HZ = 2;
  localparam int unsigned PER_MIN    = CLK_HZ / RATE_MAX_HZ;
  localparam int unsigned PER_MAX    = (CLK_HZ * 4) / RATE_MIN_QHZ;
  localparam int unsigned PER_SLOW   = CLK_HZ / SLOW_RATE_HZ;
  localparam int unsigned PER_1PPS   = CLK_HZ;
  localparam int unsigned WID_1PPS   = CLK_HZ / 10;
  localparam int unsigned SUB_W      = 26;
  localparam int unsigned SEC_W      = 6;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned SIG_W      = 4;
  localparam int unsigned FIX_MIN_SIG = 1;
  localparam int unsigned NAV_MIN_SIG = 4;
  localparam int unsigned LIGHT_DM_PER_NS = 3;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h04;
  localparam logic [7:0] OFF_PER0    = 8'h08;
  localparam logic [7:0] OFF_WID0    = 8'h0c;
  localparam logic [7:0] OFF_PER1    = 8'h10;
  localparam logic [7:0] OFF_WID1    = 8'h14;
  localparam logic [7:0] OFF_TIME_ACCURACY_THRESHOLD    = 8'h18;
  localparam logic [7:0] OFF_HOSTMIN = 8'h1c;
  localparam logic [7:0] OFF_SVSTD   = 8'h20;
  localparam logic [7:0] OFF_SVTIME  = 8'h24;
  localparam logic [7:0] OFF_STATUS  = 8'h28;
  localparam logic [7:0] OFF_SVELAP  = 8'h2c;
  localparam logic [7:0] OFF_LASTP   = 8'h30;
  localparam logic [7:0] OFF_NEXTPH  = 8'h34;
  localparam logic [7:0] OFF_E0RISE  = 8'h38;
  localparam logic [7:0] OFF_E0FALL  = 8'h3c;
  localparam logic [7:0] OFF_E0CNT   = 8'h40;
  localparam logic [7:0] OFF_E1RISE  = 8'h44;
  localparam logic [7:0] OFF_E1FALL  = 8'h48;
  localparam logic [7:0] OFF_E1CNT   = 8'h4c;
  localparam logic [7:0] OFF_QERR    = 8'h50;
  localparam logic [7:0] OFF_AIDSEC  = 8'h54;

  localparam int unsigned CB_EN0 = 0;
  localparam int unsigned CB_EN1 = 1;
  localparam int unsigned CB_BASE = 2;
  localparam int unsigned CB_MODIFY = 4;
  localparam int unsigned CB_ARM = 5;
  localparam logic [5:0] CTRL_RST = 6'h01;
  localparam logic [31:0] UNMAPPED = 32'h0;

  typedef enum logic [1:0] {BASE_UTC, BASE_GNSS, BASE_ALT} time_base_t;
  typedef enum logic [1:0] {TM_DISABLED, TM_SURVEY, TM_FIXED} time_mode_t;

  typedef struct packed {
    logic [31:0] rise_time;
    logic [31:0] fall_time;
    logic [CNT_W-1:0] count;
  } edge_stamp_t;
endpackage

// [hw/edge_capture.sv]
`timescale 1ns/1ps
module edge_capture
  import timing_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        pin,
  input  wire logic [31:0] time_now,
  output edge_stamp_t      stamp,
  output logic             rise_seen,
  output logic             edge_seen
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic change;

  // first stage feeds only the second; level moves when stages two and
  // three agree, so a single metastable sample cannot make an edge
  always_ff @(posedge ref_clk)
  begin
    s1_r <= pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  assign change    = (s2_r == s3_r) && (s3_r != level_r);
  assign edge_seen = change;
  assign rise_seen = change && s3_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      level_r <= 1'b0;
      stamp   <= '0;
    end
    else if (change)
    begin
      level_r <= s3_r;
      stamp.count <= stamp.count + 1'b1;
      if (s3_r)
        stamp.rise_time <= time_now;
      else
        stamp.fall_time <= time_now;
    end
  end
endmodule

// [hw/gnss_time_pulse_and_mark.sv]
`timescale 1ns/1ps
// What this block does
// - two pulse outputs, each rate settable from 0.25 Hz to 10 MHz
// - pulses of one second period or shorter align to UTC, satellite time, or alternate base if calibrated
// - pulse edges fall on internal clock edges, offset from ideal grid
// - below 2 Hz, phase of coming primary pulse is reported before it fires
// - report times refer to the latest pulse already emitted
// - both edges on two inputs are stamped, counted and reported
// - edge stamps use the same time base as the pulses
// - uncertainty as distance above threshold disables or marks the pulse
// - redundancy flag set while signals in use exceed required minimum
// - survey averages until deviation and time targets, then goes fixed
// - fixed mode by survey completion or host-supplied position
// - survey progress reported while survey runs
// - single-signal timing only when fixed; host may raise minimum
// - pulse suppressed in the off part of duty cycle from its second cycle on (registered output)
// - aid pulse on input zero with aid message resolves time at once
// - raw data released only after bit sync and time of week
// - after start, primary pulse enabled at one pulse per second
module gnss_time_pulse_and_mark
  import timing_pkg::*;
#(
  parameter int unsigned PER_DEF0 = PER_1PPS,
  parameter int unsigned WID_DEF0 = WID_1PPS,
  parameter int unsigned PER_TOP  = PER_MAX
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  output logic [31:0]           readdata,
  output logic                  waitrequest,
  input  wire logic             utc_epoch,
  input  wire logic             gnss_epoch,
  input  wire logic             alt_epoch,
  input  wire logic             calib_avail,
  input  wire logic [31:0]      sync_qerr,
  input  wire logic [31:0]      time_uncert_ns,
  input  wire logic [SIG_W-1:0] sigs_used,
  input  wire logic [SIG_W-1:0] sigs_min_situation,
  input  wire logic [31:0]      survey_std,
  input  wire logic             duty_off,
  input  wire logic             bit_sync,
  input  wire logic             tow_valid,
  input  wire logic             edge_in_zero,
  input  wire logic             edge_in_one,
  output logic                  pulse_out_primary,
  output logic                  pulse_out_secondary,
  output logic                  survey_progress_report,
  output logic                  redundancy_active_flag,
  output logic                  raw_out_enable,
  output logic                  timing_ok
);
  if (PER_TOP < PER_DEF0 || PER_DEF0 < PER_MIN || WID_DEF0 >= PER_DEF0)
  begin : g_bad_params
    $error("pulse defaults out of range");
  end

  logic [5:0]       ctrl_r;
  time_mode_t       mode_r;
  logic [31:0]      per_r [2];
  logic [31:0]      wid_r [2];
  logic [31:0]      time_accuracy_threshold_r;
  logic [SIG_W-1:0] hostmin_r;
  logic [31:0]      svstd_r;
  logic [31:0]      svtime_r;
  logic [31:0]      svelap_r;
  logic [31:0]      aidsec_r;
  logic [SUB_W-1:0] sub_r;
  logic [SEC_W-1:0] sec_r;
  logic [31:0]      lastp_r;
  logic [31:0]      nextph_r;
  logic [31:0]      qerr_r;
  logic             phase_rdy_r;
  logic             resolved_r;
  logic             ack_r;
  logic [31:0]      cnt_r [2];
  logic [1:0]       pulse_r;
  logic             svrep_r;

  time_base_t       base;
  logic             epoch;
  logic             alt_used;
  logic [31:0]      time_now;
  logic [SIG_W-1:0] eff_min;
  logic [33:0]      uncert_dm;
  logic             over_time_accuracy_threshold;
  logic             gate_off;
  logic             wr_en;
  logic [31:0]      wsel;
  logic [31:0]      stat;
  edge_stamp_t      st0;
  edge_stamp_t      st1;
  logic             rise0;
  logic [1:0]       edge_any;

  // base selection; alternate base needs calibration, else satellite time
  always_comb
  begin
    base = time_base_t'(ctrl_r[CB_BASE +: 2]);
    alt_used = (base == BASE_ALT) && calib_avail;
    unique case (base)
      BASE_UTC:  epoch = utc_epoch;
      BASE_GNSS: epoch = gnss_epoch;
      BASE_ALT:  epoch = calib_avail ? alt_epoch : gnss_epoch;
      default:   epoch = gnss_epoch;
    endcase
  end

  assign time_now = {sec_r, sub_r};

  // minimum signals: one only when position is fixed, never below host
  always_comb
  begin
    eff_min = (mode_r == TM_FIXED) ? SIG_W'(FIX_MIN_SIG)
                                   : SIG_W'(NAV_MIN_SIG);
    if (sigs_min_situation > eff_min)
      eff_min = sigs_min_situation;
    if (hostmin_r > eff_min)
      eff_min = hostmin_r;
  end

  assign redundancy_active_flag = sigs_used > eff_min;
  assign timing_ok = (sigs_used >= eff_min) && (mode_r != TM_SURVEY);
  assign uncert_dm = 34'(time_uncert_ns) * 34'(LIGHT_DM_PER_NS);
  assign over_time_accuracy_threshold = uncert_dm > 34'(time_accuracy_threshold_r);
  // modify option keeps the pulse running; only the status flag marks it
  assign gate_off = duty_off || !timing_ok
                    || (over_time_accuracy_threshold && !ctrl_r[CB_MODIFY]);
  assign raw_out_enable = bit_sync && tow_valid;

  // bus slave: one wait cycle, answer on the second; a write lands only
  // on the edge where the master sees waitrequest low
  assign waitrequest = (read || write) && !ack_r;
  assign wr_en = write && ack_r;
  assign wsel = writedata;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (read || write) && !ack_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      per_r[0]  <= PER_DEF0;
      wid_r[0]  <= WID_DEF0;
      per_r[1]  <= PER_DEF0;
      wid_r[1]  <= WID_DEF0;
      time_accuracy_threshold_r    <= '1;
      hostmin_r <= '0;
      svstd_r   <= '0;
      svtime_r  <= '0;
      aidsec_r  <= '0;
    end
    else if (wr_en)
    begin
      unique case (address)
        OFF_PER0, OFF_PER1:
          // rates clamp into the supported 0.25 Hz .. 10 MHz band
          per_r[address[4]] <= (wsel < PER_MIN) ? PER_MIN
                             : (wsel > PER_TOP) ? PER_TOP : wsel;
        OFF_WID0: wid_r[0] <= wsel;
        OFF_WID1: wid_r[1] <= wsel;
        OFF_TIME_ACCURACY_THRESHOLD: time_accuracy_threshold_r <= wsel;
        OFF_HOSTMIN: hostmin_r <= wsel[SIG_W-1:0];
        OFF_SVSTD: svstd_r <= wsel;
        OFF_SVTIME: svtime_r <= wsel;
        OFF_AIDSEC: aidsec_r <= wsel;
        default: ;
      endcase
    end
  end

  // arm bit: software sets it, the aid edge clears it; a set wins
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctrl_r <= CTRL_RST;
    else if (wr_en && address == OFF_CTRL)
      ctrl_r <= wsel[5:0];
    else if (rise0)
      ctrl_r[CB_ARM] <= 1'b0;
  end

  // time of day on the selected base; an armed aid edge reloads it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sub_r      <= '0;
      sec_r      <= '0;
      resolved_r <= 1'b0;
      qerr_r     <= '0;
    end
    else if (rise0 && ctrl_r[CB_ARM])
    begin
      sub_r      <= '0;
      sec_r      <= aidsec_r[SEC_W-1:0];
      resolved_r <= 1'b1;
    end
    else if (epoch)
    begin
      sub_r  <= '0;
      sec_r  <= sec_r + 1'b1;
      qerr_r <= sync_qerr;
    end
    else
      sub_r <= sub_r + 1'b1;
  end

  // time mode sequence
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_r   <= TM_DISABLED;
      svelap_r <= '0;
      svrep_r  <= 1'b0;
    end
    else
    begin
      svrep_r <= 1'b0;
      if (wr_en && address == OFF_MODE)
      begin
        // writing fixed stands for a supplied position with uncertainty
        mode_r   <= time_mode_t'(wsel[1:0]);
        svelap_r <= '0;
      end
      else if (mode_r == TM_SURVEY && epoch)
      begin
        svelap_r <= svelap_r + 1'b1;
        svrep_r  <= 1'b1;
        if (survey_std <= svstd_r && svelap_r >= svtime_r)
          mode_r <= TM_FIXED;
      end
    end
  end
  assign survey_progress_report = svrep_r;

  // pulse generators; edges can only move on ref_clk, hence the offset
  // that is published in the quantisation register
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_pulse
    logic enabled;
    assign enabled = ctrl_r[ch];
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        cnt_r[ch]   <= '0;
        pulse_r[ch] <= 1'b0;
      end
      else
      begin
        // long periods cannot realign on every second epoch
        if (epoch && per_r[ch] <= PER_1PPS)
          cnt_r[ch] <= '0;
        else if (cnt_r[ch] >= per_r[ch] - 1)
          cnt_r[ch] <= '0;
        else
          cnt_r[ch] <= cnt_r[ch] + 1;
        pulse_r[ch] <= enabled && !gate_off
                       && (cnt_r[ch] < wid_r[ch]);
      end
    end
  end
  assign pulse_out_primary   = pulse_r[0];
  assign pulse_out_secondary = pulse_r[1];

  // slow primary: publish the coming edge half a period ahead; keep the
  // time of the last emitted pulse for reports
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      nextph_r    <= '0;
      phase_rdy_r <= 1'b0;
      lastp_r     <= '0;
    end
    else
    begin
      if (per_r[0] > PER_SLOW && cnt_r[0] == (per_r[0] >> 1))
      begin
        nextph_r    <= qerr_r;
        phase_rdy_r <= 1'b1;
      end
      else if (cnt_r[0] == '0)
        phase_rdy_r <= 1'b0;
      if (pulse_out_primary == 1'b0 && cnt_r[0] == '0 && ctrl_r[CB_EN0]
          && !gate_off)
        lastp_r <= time_now;
    end
  end

  edge_capture u_cap0
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin       (edge_in_zero),
    .time_now  (time_now),
    .stamp     (st0),
    .rise_seen (rise0),
    .edge_seen (edge_any[0])
  );

  edge_capture u_cap1
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin       (edge_in_one),
    .time_now  (time_now),
    .stamp     (st1),
    .rise_seen (),
    .edge_seen (edge_any[1])
  );

  assign stat = {22'h0, alt_used, resolved_r, phase_rdy_r, mode_r,
                 mode_r == TM_SURVEY, raw_out_enable,
                 redundancy_active_flag, over_time_accuracy_threshold, |edge_any};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      readdata <= '0;
    else if (read && !ack_r)
    begin
      unique case (address)
        OFF_CTRL:    readdata <= {26'h0, ctrl_r};
        OFF_MODE:    readdata <= {30'h0, mode_r};
        OFF_PER0:    readdata <= per_r[0];
        OFF_WID0:    readdata <= wid_r[0];
        OFF_PER1:    readdata <= per_r[1];
        OFF_WID1:    readdata <= wid_r[1];
        OFF_TIME_ACCURACY_THRESHOLD:    readdata <= time_accuracy_threshold_r;
        OFF_HOSTMIN: readdata <= {28'h0, hostmin_r};
        OFF_SVSTD:   readdata <= svstd_r;
        OFF_SVTIME:  readdata <= svtime_r;
        OFF_STATUS:  readdata <= stat;
        OFF_SVELAP:  readdata <= svelap_r;
        OFF_LASTP:   readdata <= lastp_r;
        OFF_NEXTPH:  readdata <= nextph_r;
        OFF_E0RISE:  readdata <= st0.rise_time;
        OFF_E0FALL:  readdata <= st0.fall_time;
        OFF_E0CNT:   readdata <= {16'h0, st0.count};
        OFF_E1RISE:  readdata <= st1.rise_time;
        OFF_E1FALL:  readdata <= st1.fall_time;
        OFF_E1CNT:   readdata <= {16'h0, st1.count};
        OFF_QERR:    readdata <= qerr_r;
        OFF_AIDSEC:  readdata <= aidsec_r;
        default:     readdata <= UNMAPPED;
      endcase
    end
  end
endmodule

// [verif/tpm_checker.sv]
`timescale 1ns/1ps
module tpm_checker
  import timing_pkg::*;
#(
  parameter int unsigned PER_DEF0 = PER_1PPS,
  parameter int unsigned WID_DEF0 = WID_1PPS,
  parameter int unsigned PER_TOP  = PER_MAX
)
(
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             read,
  input wire logic             write,
  input wire logic             waitrequest,
  input wire logic [SIG_W-1:0] sigs_used,
  input wire logic [SIG_W-1:0] sigs_min_situation,
  input wire logic             duty_off,
  input wire logic             bit_sync,
  input wire logic             tow_valid,
  input wire logic             pulse_out_primary,
  input wire logic             pulse_out_secondary,
  input wire logic             survey_progress_report,
  input wire logic             redundancy_active_flag,
  input wire logic             raw_out_enable,
  input wire logic             timing_ok
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_raw_on: assert property (bit_sync && tow_valid |-> raw_out_enable)
    else $error("raw output not enabled");
  chk_raw_off: assert property (raw_out_enable |-> bit_sync && tow_valid)
    else $error("raw output enabled early");
  chk_redund_low: assert property
    (sigs_used <= sigs_min_situation |-> !redundancy_active_flag)
    else $error("redundancy flag without spare signals");
  // outputs are registered, so the gate shows one cycle later
  chk_duty_gate: assert property (duty_off ##1 duty_off |->
    !pulse_out_primary && !pulse_out_secondary)
    else $error("pulse during off section");
  chk_ok_gate: assert property
    (!timing_ok ##1 !timing_ok |-> !pulse_out_primary)
    else $error("pulse without valid timing");
  chk_fix_min: assert property (timing_ok |-> sigs_used >= FIX_MIN_SIG)
    else $error("timing valid with no signal");
  chk_survey_pulse: assert property
    (survey_progress_report |=> !survey_progress_report)
    else $error("survey report longer than one cycle");
  chk_wait_first: assert property
    ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");
  chk_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("wait asserted while idle");

  cover property ($rose(pulse_out_primary));
  cover property (survey_progress_report);
  cover property (redundancy_active_flag);
  cover property (duty_off ##1 duty_off);
endmodule

// [verif/host_model.sv]
`timescale 1ns/1ps
module host_model
(
  input  wire logic        ref_clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata
);
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end

  // one idle edge first, so back-to-back calls never drive twice at once
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// [verif/gnss_time_pulse_and_mark_tb.sv]
`timescale 1ns/1ps
module gnss_time_pulse_and_mark_tb;
  import timing_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d, q;} row_t;
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       address;
  logic             read;
  logic             write;
  logic [31:0]      writedata;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic             utc_epoch = 1'b0;
  logic             gnss_epoch = 1'b0;
  logic             alt_epoch = 1'b0;
  logic             calib_avail = 1'b0;
  logic [31:0]      sync_qerr = 32'h0;
  logic [31:0]      time_uncert_ns = 32'h0;
  logic [SIG_W-1:0] sigs_used = 4'h4;
  logic [SIG_W-1:0] sigs_min_situation = 4'h1;
  logic [31:0]      survey_std = 32'hc8;
  logic             duty_off = 1'b0;
  logic             bit_sync = 1'b0;
  logic             tow_valid = 1'b0;
  logic             edge_in_zero = 1'b0;
  logic             edge_in_one = 1'b0;
  logic             pulse_out_primary;
  logic             pulse_out_secondary;
  logic             survey_progress_report;
  logic             redundancy_active_flag;
  logic             raw_out_enable;
  logic             timing_ok;
  logic [31:0]      q;
  int               fail_count = 0;
  int               total_checks = 0;
  int               svp = 0;
  row_t rows [10] = '{
    '{1'b0, OFF_CTRL, 32'h0, 32'h1}, '{1'b0, OFF_PER0, 32'h0, 32'd40},
    '{1'b0, OFF_WID0, 32'h0, 32'd4}, '{1'b0, OFF_TIME_ACCURACY_THRESHOLD, 32'h0, 32'hffffffff},
    '{1'b0, 8'hfc, 32'h0, UNMAPPED}, '{1'b1, 8'hfc, 32'h5a, UNMAPPED},
    '{1'b1, OFF_PER1, 32'd100, 32'd100}, '{1'b1, OFF_PER1, 32'd1, 32'd4},
    '{1'b1, OFF_PER1, 32'd500, 32'd400}, '{1'b1, OFF_WID1, 32'd2, 32'd2}};

  // short period keeps the pulse tests to a few hundred cycles
  gnss_time_pulse_and_mark #(.PER_DEF0(40), .WID_DEF0(4), .PER_TOP(400))
    DUT (.*);
  host_model host (.*);

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (survey_progress_report === 1'b1)
      svp++;

  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    host.xfer(1'b1, a, d, dummy);
  endtask
  task automatic hi(input logic sel, input int n, input int exp,
                    input string m);
    int c;
    c = 0;
    repeat (8) @(posedge ref_clk);
    repeat (n)
    begin
      @(posedge ref_clk);
      c += int'(sel ? pulse_out_secondary : pulse_out_primary);
    end
    chk(32'(c), 32'(exp), m);
  endtask
  task automatic sig(input logic [SIG_W-1:0] v, input logic exp);
    @(posedge ref_clk);
    sigs_used <= v;
    @(posedge ref_clk);
    chk(32'(timing_ok), 32'(exp), "timing ok");
  endtask
  task automatic tog(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      edge_in_zero <= ~edge_in_zero;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  task automatic epochs(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      utc_epoch <= 1'b1;
      @(posedge ref_clk);
      utc_epoch <= 1'b0;
      repeat (20) @(posedge ref_clk);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(q, rows[i].q, "register");
    end
    $display("register table done");
    hi(1'b0, 400, 40, "default primary");
    wr(OFF_CTRL, 32'h03);
    hi(1'b1, 400, 2, "secondary rate");
    @(posedge ref_clk);
    duty_off <= 1'b1;
    hi(1'b0, 400, 0, "primary off section");
    hi(1'b1, 400, 0, "secondary off section");
    duty_off <= 1'b0;
    $display("pulse tests done");
    wr(OFF_TIME_ACCURACY_THRESHOLD, 32'd10);
    time_uncert_ns <= 32'd10;
    hi(1'b0, 400, 0, "over threshold");
    rd(OFF_STATUS);
    chk(32'(q[1]), 32'h1, "over flag");
    wr(OFF_CTRL, 32'h13);
    hi(1'b0, 400, 40, "modify keeps pulse");
    time_uncert_ns <= 32'h0;
    wr(OFF_CTRL, 32'h03);
    $display("threshold done");
    sig(4'h2, 1'b0);
    hi(1'b0, 400, 0, "too few signals");
    wr(OFF_HOSTMIN, 32'd2);
    wr(OFF_MODE, 32'd2);
    sig(4'h2, 1'b1);
    chk(32'(redundancy_active_flag), 32'h0, "no spare");
    sig(4'h3, 1'b1);
    chk(32'(redundancy_active_flag), 32'h1, "spare signal");
    sigs_min_situation <= 4'h3;
    sig(4'h3, 1'b1);
    chk(32'(redundancy_active_flag), 32'h0, "situation min");
    sigs_min_situation <= 4'h1;
    sig(4'h1, 1'b0);
    wr(OFF_HOSTMIN, 32'd0);
    sig(4'h1, 1'b1);
    wr(OFF_MODE, 32'd0);
    sig(4'h1, 1'b0);
    sig(4'h4, 1'b1);
    $display("signal count done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      {bit_sync, tow_valid} <= 2'(i);
      @(posedge ref_clk);
      chk(32'(raw_out_enable), 32'(i == 3), "raw enable");
    end
    $display("raw data done");
    wr(OFF_CTRL, 32'h0b);
    calib_avail <= 1'b1;
    rd(OFF_STATUS);
    chk(32'(q[9]), 32'h1, "alt base used");
    calib_avail <= 1'b0;
    rd(OFF_STATUS);
    chk(32'(q[9]), 32'h0, "alt base uncalibrated");
    $display("time base done");
    wr(OFF_AIDSEC, 32'd5);
    wr(OFF_CTRL, 32'h23);
    tog(6);
    @(posedge ref_clk);
    edge_in_one <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(OFF_E0CNT);
    chk(q, 32'd6, "count zero");
    rd(OFF_E1CNT);
    chk(q, 32'd1, "count one");
    rd(OFF_STATUS);
    chk(32'(q[8]), 32'h1, "aid resolved");
    rd(OFF_E0RISE);
    chk(32'(q[31:26]), 32'd5, "rise seconds");
    rd(OFF_E0FALL);
    chk(32'(q[31:26]), 32'd5, "fall seconds");
    $display("edge stamps done");
    sync_qerr <= 32'h2a;
    wr(OFF_SVSTD, 32'd100);
    wr(OFF_SVTIME, 32'd2);
    wr(OFF_MODE, 32'd1);
    sig(4'h4, 1'b0);
    epochs(3);
    rd(OFF_MODE);
    chk(q, 32'd1, "deviation not met");
    rd(OFF_QERR);
    chk(q, 32'h2a, "quantisation offset");
    survey_std <= 32'd50;
    epochs(2);
    rd(OFF_MODE);
    chk(q, 32'd2, "survey complete");
    chk(32'(svp != 0), 32'h1, "survey reports");
    $display("survey done");
    // second reset in mid-run: defaults must come back
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFF_CTRL);
    chk(q, 32'h1, "ctrl after reset");
    rd(OFF_MODE);
    chk(q, 32'h0, "mode after reset");
    hi(1'b0, 400, 40, "primary after reset");
    $display("reset done");
    close_out();
  end
endmodule

bind gnss_time_pulse_and_mark tpm_checker #(.PER_DEF0(PER_DEF0),
  .WID_DEF0(WID_DEF0), .PER_TOP(PER_TOP)) u_chk (.*);
